// ===== hw/sac_params.svh
// sac_params.svh - named constants of the sar conversion sequencer
// assumes: included by bare name from the package and the sac_conv_ctrl module
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// core clock rate
`define SAC_CORE_CLK_MHZ      250
`define SAC_CORE_CLK_KHZ      250000

// conversion clock ceiling; divider rounds up so the rate stays below it
`define SAC_CONV_CLK_MAX_KHZ  14000
`define SAC_CONV_DIV          ((`SAC_CORE_CLK_KHZ + `SAC_CONV_CLK_MAX_KHZ - 1) / `SAC_CONV_CLK_MAX_KHZ)

// power-up wait, a least time, so rounded up
`define SAC_PWRUP_WAIT_NS     10000
`define SAC_PWRUP_CYCLES      ((`SAC_PWRUP_WAIT_NS * `SAC_CORE_CLK_MHZ + 999) / 1000)

// result layout and sequencing
`define SAC_RES_BITS          12
`define SAC_SAMPLE_TICKS      2
`define SAC_RESULT_RST        16'h0000

`endif

// ===== hw/sac_pkg.sv
// sac_pkg.sv - types of the sar conversion sequencer
// assumes: sac_params.svh is on the include path
`include "sac_params.svh"

package sac_pkg;

   typedef enum logic [4:0] {
      SAC_OFF    = 5'b0_0001,
      SAC_WAKE   = 5'b0_0010,
      SAC_IDLE   = 5'b0_0100,
      SAC_SAMPLE = 5'b0_1000,
      SAC_CONV   = 5'b1_0000
   } sac_state_t;

endpackage

// ===== hw/sac_tick_gen.sv
// sac_tick_gen.sv - conversion clock enable divider
// assumes: one core clock; tick is a one-cycle enable, never a clock
`timescale 1ns/1ps

module sac_tick_gen #(
   parameter int DIV = 18
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic run_i,
   // enable out
   output logic      tick_o
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   generate
      if (DIV < 2) begin : g_bad_div
         $error("sac_tick_gen: DIV must be at least 2");
      end
   endgenerate

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   wire           at_last = (cnt_reg == LAST);

   // restart on every run so the first tick is a full period late
   assign cnt_next = (!run_i || at_last) ? '0 : cnt_reg + CW'(1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= run_i && at_last;
      end
   end

   assign tick_o = tick_reg;

endmodule // sac_tick_gen

// ===== hw/sac_conv_ctrl.sv
// sac_conv_ctrl.sv - successive approximation conversion sequencer
// assumes: analog comparator and dac outside; comparator output and the
// start-of-frame input are asynchronous; control bits come from logic on
// the core clock; power controller drives a level that is high when on.
//
// Contract
// - resolve bits by binary search on the dac, msb first to lsb
// - results are 12 bits; throughput reaches at least 700 ksps
// - start bit or start-of-frame input begins a conversion
// - continuous mode converts with start-of-frame left unconnected
// - no conversion until 10 us after power-up or wake
// - on completion set done status, hold end-of-frame until read
// - end-of-frame is usable as an interrupt or dma request
// - single bit picks one per trigger or back-to-back conversions
// - continuous results move by dma, each read outside a completion cycle clears end-of-frame
`timescale 1ns/1ps

`include "sac_params.svh"

module sac_conv_ctrl
   import sac_pkg::*;
#(
   parameter int RES_BITS     = `SAC_RES_BITS,
   parameter int SAMPLE_TICKS = `SAC_SAMPLE_TICKS,
   parameter int CONV_DIV     = `SAC_CONV_DIV,
   parameter int PWRUP_CYCLES = `SAC_PWRUP_CYCLES
) (
   // clock and reset
   input  wire logic                CORE_CLK_I,
   input  wire logic                RST_I,
   // power and control
   input  wire logic                PWR_ON_I,
   input  wire logic                START_I,
   input  wire logic                SINGLE_I,
   input  wire logic                SOF_I,
   // result read by cpu or dma
   input  wire logic                RD_I,
   // analog front end
   input  wire logic                CMP_I,
   output logic [RES_BITS-1:0]      DAC_CODE_O,
   output logic                     SAMPLE_O,
   // status
   output logic                     READY_O,
   output logic                     BUSY_O,
   output logic                     DONE_O,
   output logic                     EOF_O,
   output logic [RES_BITS-1:0]      RESULT_O
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   localparam int IW = $clog2(RES_BITS);
   localparam int SW = $clog2(SAMPLE_TICKS + 1);
   localparam int WW = $clog2(PWRUP_CYCLES + 1);
   localparam logic [WW-1:0] WAIT_LAST = WW'(PWRUP_CYCLES - 1);
   localparam logic [SW-1:0] SAMP_LAST = SW'(SAMPLE_TICKS - 1);
   localparam logic [IW-1:0] MSB_IDX   = IW'(RES_BITS - 1);
   localparam int CONV_KHZ = `SAC_CORE_CLK_KHZ / CONV_DIV;

   generate
      if (RES_BITS < 2 || RES_BITS > 16) begin : g_bad_res
         $error("sac_conv_ctrl: RES_BITS must be 2 to 16");
      end
      if (SAMPLE_TICKS < 1) begin : g_bad_samp
         $error("sac_conv_ctrl: SAMPLE_TICKS must be at least 1");
      end
      if (PWRUP_CYCLES < 1) begin : g_bad_wait
         $error("sac_conv_ctrl: PWRUP_CYCLES must be at least 1");
      end
      if (CONV_KHZ > `SAC_CONV_CLK_MAX_KHZ) begin : g_bad_div
         $error("sac_conv_ctrl: conversion clock too fast");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // binary search step

   // decide bit idx from the comparator, then try the next lower bit
   function automatic logic [RES_BITS-1:0] sar_step(
      input logic [RES_BITS-1:0] trial,
      input logic [IW-1:0]       idx,
      input logic                keep
   );
      logic [RES_BITS-1:0] v;
      v      = trial;
      v[idx] = keep;
      if (idx != '0) begin
         v[idx - IW'(1)] = 1'b1;
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic sof_meta_reg;
   logic sof_sync_reg;
   logic sof_prev_reg;
   logic cmp_meta_reg;
   logic cmp_sync_reg;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         sof_meta_reg <= 1'b0;
         sof_sync_reg <= 1'b0;
         sof_prev_reg <= 1'b0;
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end else begin
         sof_meta_reg <= SOF_I;
         sof_sync_reg <= sof_meta_reg;
         sof_prev_reg <= sof_sync_reg;
         cmp_meta_reg <= CMP_I;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   // a held-high frame input starts only one conversion
   wire sof_rise = sof_sync_reg & ~sof_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // conversion clock enable

   sac_state_t state_reg;
   sac_state_t state_next;
   logic       tick;

   wire in_wake   = (state_reg == SAC_WAKE);
   wire in_idle   = (state_reg == SAC_IDLE);
   wire in_sample = (state_reg == SAC_SAMPLE);
   wire in_conv   = (state_reg == SAC_CONV);
   wire running   = in_sample | in_conv;

   sac_tick_gen #(
      .DIV    (CONV_DIV)
   ) u_tick (
      .clk_i  (CORE_CLK_I),
      .rst_i  (RST_I),
      .run_i  (running),
      .tick_o (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencing decode

   logic [WW-1:0]       wait_reg;
   logic [SW-1:0]       samp_reg;
   logic [IW-1:0]       idx_reg;
   logic [RES_BITS-1:0] trial_reg;
   logic [RES_BITS-1:0] result_reg;
   logic                done_reg;
   logic                eof_reg;

   wire wait_over = in_wake && (wait_reg == WAIT_LAST);
   // continuous mode needs no trigger at all
   wire trigger   = START_I | sof_rise | ~SINGLE_I;
   wire start_ok  = in_idle && trigger;
   wire samp_done = in_sample && tick && (samp_reg == SAMP_LAST);
   wire last_bit  = in_conv && tick && (idx_reg == '0);
   wire [RES_BITS-1:0] trial_step = sar_step(trial_reg, idx_reg,
                                             cmp_sync_reg);

   always_comb begin
      state_next = state_reg;
      if (!PWR_ON_I) begin
         state_next = SAC_OFF;
      end else begin
         case (state_reg)
            SAC_OFF:    state_next = SAC_WAKE;
            SAC_WAKE:   if (wait_over) state_next = SAC_IDLE;
            SAC_IDLE:   if (start_ok) state_next = SAC_SAMPLE;
            SAC_SAMPLE: if (samp_done) state_next = SAC_CONV;
            SAC_CONV: begin
               if (last_bit) begin
                  // back to back unless one-shot
                  state_next = SINGLE_I ? SAC_IDLE : SAC_SAMPLE;
               end
            end
            default:    state_next = SAC_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state and counters

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state_reg <= SAC_OFF;
         wait_reg  <= '0;
         samp_reg  <= '0;
      end else begin
         state_reg <= state_next;
         wait_reg  <= in_wake ? wait_reg + WW'(1) : '0;
         if (!in_sample) begin
            samp_reg <= '0;
         end else if (tick) begin
            samp_reg <= samp_reg + SW'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // successive approximation register

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         idx_reg   <= MSB_IDX;
         trial_reg <= RES_BITS'(`SAC_RESULT_RST);
      end else if (samp_done) begin
         // first trial is mid-scale
         idx_reg   <= MSB_IDX;
         trial_reg <= RES_BITS'(1) << MSB_IDX;
      end else if (in_conv && tick) begin
         idx_reg   <= idx_reg - IW'(1);
         trial_reg <= trial_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result and completion flags

   // a completion in the read cycle wins so no result goes unannounced
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         result_reg <= RES_BITS'(`SAC_RESULT_RST);
         done_reg   <= 1'b0;
         eof_reg    <= 1'b0;
      end else if (last_bit) begin
         result_reg <= trial_step;
         done_reg   <= 1'b1;
         eof_reg    <= 1'b1;
      end else if (RD_I) begin
         done_reg   <= 1'b0;
         eof_reg    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign DAC_CODE_O = trial_reg;
   assign SAMPLE_O   = in_sample;
   assign READY_O    = in_idle;
   assign BUSY_O     = running;
   assign DONE_O     = done_reg;
   // level held until read; fits a level interrupt or a dma request
   assign EOF_O      = eof_reg;
   assign RESULT_O   = result_reg;

endmodule // sac_conv_ctrl

// ===== test/sac_conv_ctrl_properties.sv
// sac_conv_ctrl_properties.sv - port checks of the sar sequencer
// assumes: bound into sac_conv_ctrl; one clock, synchronous reset
`timescale 1ns/1ps

module sac_conv_ctrl_properties #(
   parameter int RES_BITS     = 12,
   parameter int PWRUP_CYCLES = 2500
) (
   // clock and control
   input wire logic                CORE_CLK_I,
   input wire logic                RST_I,
   input wire logic                PWR_ON_I,
   input wire logic                START_I,
   input wire logic                SINGLE_I,
   input wire logic                RD_I,
   // sequencer outputs
   input wire logic [RES_BITS-1:0] DAC_CODE_O,
   input wire logic                SAMPLE_O,
   input wire logic                READY_O,
   input wire logic                BUSY_O,
   input wire logic                DONE_O,
   input wire logic                EOF_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // cycles of power held high since reset or the last power loss, stopping at PWRUP_CYCLES
   int on_cnt;
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || !PWR_ON_I) begin
         on_cnt <= 0;
      end else if (on_cnt < PWRUP_CYCLES) begin
         on_cnt <= on_cnt + 1;
      end
   end
   // conversion phase opens where sampling ends
   sequence s_conv;
      BUSY_O && $fell(SAMPLE_O);
   endsequence
   ////////////////////////////////////////
   a_start_taken: assert property (
      READY_O && START_I && PWR_ON_I |=> BUSY_O && SAMPLE_O && !READY_O)
      else $error("start not taken");
   a_ready_wait: assert property (
      $rose(READY_O) |-> on_cnt >= PWRUP_CYCLES)
      else $error("ready before wake wait");
   a_msb_first: assert property (
      s_conv |-> ##[0:1] DAC_CODE_O == (1 << (RES_BITS - 1)))
      else $error("first trial not msb");
   a_trial_hold: assert property (
      BUSY_O && !SAMPLE_O && $changed(DAC_CODE_O) |=>
      (SAMPLE_O || !BUSY_O || $stable(DAC_CODE_O)) [*8])
      else $error("trial step too fast");
   a_conv_span: assert property (
      (s_conv and SINGLE_I) |->
      (BUSY_O throughout ##200 1'b1) ##[1:30] !BUSY_O)
      else $error("conversion length off");
   a_eof_sticky: assert property (
      EOF_O && !RD_I |=> EOF_O)
      else $error("end of frame dropped unread");
   a_read_clear: assert property (
      RD_I && !BUSY_O |=> !EOF_O && !DONE_O)
      else $error("read left flags set");
   a_cont_next: assert property (
      $rose(EOF_O) && !SINGLE_I && PWR_ON_I |-> ##[0:2] SAMPLE_O)
      else $error("continuous mode stalled");
endmodule // sac_conv_ctrl_properties

// ===== test/sac_front_model.sv
// sac_front_model.sv - analog input and result reader of the sequencer
// assumes: same core clock; vin held steady through a conversion
`timescale 1ns/1ps

module sac_front_model (
   // clock and sequencer outputs
   input  wire logic        clk_i,
   input  wire logic [11:0] dac_code_i,
   input  wire logic        eof_i,
   // scenario control
   input  wire logic [11:0] vin_i,
   input  wire logic        rd_auto_i,
   input  wire logic        rd_now_i,
   // to the sequencer
   output logic             cmp_o,
   output logic             rd_o
);
   logic [2:0] wait_reg = 3'h0;

   // ideal comparator, high keeps the trial bit
   assign cmp_o = (vin_i >= dac_code_i);

   // reader answers slowly: a few cycles after end of frame
   initial rd_o = 1'b0;
   always @(posedge clk_i) begin
      if (!(eof_i && rd_auto_i) || rd_o) wait_reg <= 3'h0;
      else wait_reg <= wait_reg + 3'h1;
      rd_o <= rd_now_i || (rd_auto_i && eof_i && wait_reg == 3'h4);
   end
endmodule // sac_front_model

// ===== test/test_sac_conv_ctrl.sv
// test_sac_conv_ctrl.sv - self-checking bench of the sar sequencer
// assumes: sequencer, properties and front model compiled before it
`timescale 1ns/1ps

`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin \
   failures++; $display("[ERR] %0t %s", $time, m); end end

module test_sac_conv_ctrl;
   localparam int PWRUP = 20;
   logic        clk, rst, pwr_on, start, single, sof, rd_now, rd_auto;
   logic        cmp, rd, sample, ready, busy, done, eof;
   logic [11:0] vin, dac_code, result;
   int          failures, n_tests, cyc;

   sac_conv_ctrl #(.PWRUP_CYCLES(PWRUP)) sac_conv_ctrl_inst (
      .CORE_CLK_I(clk), .RST_I(rst), .PWR_ON_I(pwr_on), .START_I(start),
      .SINGLE_I(single), .SOF_I(sof), .RD_I(rd), .CMP_I(cmp),
      .DAC_CODE_O(dac_code), .SAMPLE_O(sample), .READY_O(ready),
      .BUSY_O(busy), .DONE_O(done), .EOF_O(eof), .RESULT_O(result));
   sac_front_model sac_front_model_inst (
      .clk_i(clk), .dac_code_i(dac_code), .eof_i(eof), .vin_i(vin),
      .rd_auto_i(rd_auto), .rd_now_i(rd_now), .cmp_o(cmp), .rd_o(rd));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // run is near 2600 cycles; ceiling leaves a wide margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         `CHK(1'b0, 1'b1, "timeout")
         print_verdict();
      end
   end
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_sig(ref logic s, input logic v, output int k);
      k = 0;
      while (s !== v && k < 400) begin
         @(negedge clk);
         k++;
      end
      if (k >= 400) begin
         failures++;
         $display("[ERR] %0t wait limit reached", $time);
      end
   endtask

   task automatic do_read();
      @(posedge clk);
      rd_now <= 1'b1;
      @(posedge clk);
      rd_now <= 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // early start during the wake wait must be refused
   task automatic wait_ready();
      int k;
      start <= 1'b1;
      repeat (4) @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      `CHK(busy, 1'b0, "early start taken")
      wait_sig(ready, 1'b1, k);
      `CHK(k > PWRUP - 8, 1'b1, "ready too soon")
   endtask

   // late start and frame edge land mid conversion
   task automatic t_single(input logic [11:0] v, input logic by_sof);
      int k;
      @(posedge clk);
      vin <= v;
      start <= !by_sof;
      sof <= by_sof;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(sample & busy & !ready, 1'b1, "not sampling")
      repeat (60) @(posedge clk);
      start <= 1'b1;
      sof <= 1'b0;
      @(posedge clk);
      start <= 1'b0;
      sof <= 1'b1;
      wait_sig(eof, 1'b1, k);
      `CHK(result, v, "wrong result")
      `CHK(done, 1'b1, "no done status")
      repeat (40) @(negedge clk);
      `CHK({eof, busy}, 2'b10, "flag lost or rerun")
      @(posedge clk);
      sof <= 1'b0;
      do_read();
      `CHK({eof, done}, 2'b00, "read left flags")
   endtask

   // free run, no trigger, reader clears each frame
   task automatic t_cont();
      int k;
      int n;
      logic e0;
      k = 0;
      n = 0;
      e0 = 1'b0;
      @(posedge clk);
      vin <= 12'h3C5;
      single <= 1'b0;
      rd_auto <= 1'b1;
      while (n < 3 && k < 1000) begin
         @(negedge clk);
         k++;
         if (eof === 1'b1 && !e0) begin
            n++;
            `CHK(result, 12'h3C5, "stream value")
         end
         e0 = (eof === 1'b1);
      end
      `CHK(n, 3, "stream too slow")
      @(posedge clk);
      single <= 1'b1;
      rd_auto <= 1'b0;
      wait_sig(busy, 1'b0, k);
      do_read();
      `CHK({busy, eof}, 2'b00, "did not stop")
   endtask

   initial begin
      rst = 1'b1;
      pwr_on = 1'b1;
      start = 1'b0;
      single = 1'b1;
      sof = 1'b0;
      rd_now = 1'b0;
      rd_auto = 1'b0;
      vin = 12'h000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_ready();
      t_single(12'h000, 1'b0);
      t_single(12'hFFF, 1'b1);
      t_single(12'h800, 1'b0);
      t_single(12'h7FF, 1'b1);
      t_cont();
      @(posedge clk);
      pwr_on <= 1'b0;
      repeat (4) @(posedge clk);
      pwr_on <= 1'b1;
      wait_ready();
      t_single(12'hA5A, 1'b1);
      print_verdict();
   end
endmodule // test_sac_conv_ctrl

bind sac_conv_ctrl sac_conv_ctrl_properties #(
   .RES_BITS(RES_BITS), .PWRUP_CYCLES(PWRUP_CYCLES)
) sac_conv_ctrl_properties_inst (
   .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .PWR_ON_I(PWR_ON_I),
   .START_I(START_I), .SINGLE_I(SINGLE_I), .RD_I(RD_I),
   .DAC_CODE_O(DAC_CODE_O), .SAMPLE_O(SAMPLE_O), .READY_O(READY_O),
   .BUSY_O(BUSY_O), .DONE_O(DONE_O), .EOF_O(EOF_O));
